// >>> hdl/adc_cfg_regs.sv
// serial configuration port and register bank of a multi-converter sampling device
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_map.svh"

// Summary of operation
// R1: bit six of port config high means serial bits arrive least significant first.
// R2: writing soft reset high returns registers to defaults, except the exempt ones.
// R3: host writes low nibble mirroring upper nibble and keeps the reserved bit high.
// R4: burst end register holds final address; continuous transfers stop there.
// R5: die identifier and revision are read-only at two consecutive addresses.
// R6: converter index resets to zero; host addresses exactly one converter.
// R7: indexed read with improper index returns the fixed error code instead.
// R8: offset trims are 8-bit; 0x80 no shift, 0x00 most negative, 0xFF most positive.
// R9: trim defaults are the self-calibration results, not fixed constants.
// R10: host steps a trim by read, modify and write back to the same address.
// R11: coarse gain is four independent weight bits.
// R12: medium and fine gain are 8-bit with 0x80 as zero change.
// R13: power field 000 defers to pin, else 001 normal, 010 nap, 100 sleep.
// R14: serial power control affects only the indexed converter; pin is global.
// R15: power, divider and output mode registers survive soft reset.
// R16: nap entry writes index one, nap, index two, nap.
// R17: normal resume writes index one, normal, index two, normal.
// R18: writing zero then one to slip bit advances divided clock when dividing by four.
// R19: divider field 000 defers to pin, else 001 by one, 010 by two, 100 by four.
// R20: driver field bits 7:5 defer to pin or pick 2mA, 3mA or CMOS.
// R21: coding field bits 2:0 defer to pin or pick two's complement, gray, offset.
// R22: DLL range bit six selects slow or fast, fast after reset.
// R23: double rate register is set by read, XOR with status, XOR desired, write.
// R24: port config bit seven enables the dedicated serial output pin.
// R25: each frame opens with read flag, 2-bit count code and 13-bit address.
module adc_cfg_regs #(
	parameter int NUM_CONV = 2,
	parameter logic [7:0] DIE_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] DIE_REV = 8'h01 // arbitrary value
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic CHIP_SELECT_BAR,
	input wire logic SCLK,
	input wire logic SERIAL_DATA_I,
	output logic SERIAL_DATA_O,
	output logic SERIAL_DATA_OE,
	output logic SERIAL_OUT_PIN_O,
	output logic SERIAL_OUT_PIN_OE,
	input wire logic CAL_LOAD,
	input wire logic [39:0] CAL_TRIM [NUM_CONV],
	input wire adc_cfg_pkg::pwr_mode_t POWER_DOWN_PIN,
	input wire adc_cfg_pkg::div_t DIVIDER_SELECT_PIN,
	input wire adc_cfg_pkg::drive_t DRIVER_MODE_PIN,
	input wire adc_cfg_pkg::coding_t CODING_FORMAT_PIN,
	output adc_cfg_pkg::pwr_mode_t PWR_MODE [NUM_CONV],
	output adc_cfg_pkg::div_t DIV_RATIO,
	output adc_cfg_pkg::drive_t DRIVER_MODE,
	output adc_cfg_pkg::coding_t CODING,
	output logic DIV_ADVANCE,
	output logic DDR_ENABLE,
	output logic DLL_SLOW,
	output logic [7:0] TRIM_OFS_C [NUM_CONV],
	output logic [7:0] TRIM_OFS_F [NUM_CONV],
	output logic [3:0] TRIM_GAIN_C [NUM_CONV],
	output logic [7:0] TRIM_GAIN_M [NUM_CONV],
	output logic [7:0] TRIM_GAIN_F [NUM_CONV]
);
	import adc_cfg_pkg::*;

	if (NUM_CONV < 1 || NUM_CONV > 8) begin : g_chk
		$error("NUM_CONV must lie between 1 and 8");
	end

	// one-hot field picks an override, anything else falls back to the pin
	function automatic logic [1:0] pick(input logic [2:0] field, input logic [1:0] pin);
		logic [1:0] r;
		r = pin;
		case (field)
			3'b001: r = 2'b00;
			3'b010: r = 2'b01;
			3'b100: r = 2'b10;
			default: r = pin;
		endcase
		return r;
	endfunction

	// pin synchronisers; stage one feeds stage two only
	logic [2:0] sync1_q, sync2_q;
	logic [7:0] pins1_q, pins2_q;
	logic sclk_prev_q;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			// idle levels: select high, clock low, so no false clock edge follows reset
			sync1_q <= 3'h4;
			sync2_q <= 3'h4;
			pins1_q <= 8'h00;
			pins2_q <= 8'h00;
			sclk_prev_q <= 1'b0;
		end else if (CE) begin
			sync1_q <= {CHIP_SELECT_BAR, SCLK, SERIAL_DATA_I};
			sync2_q <= sync1_q;
			pins1_q <= {POWER_DOWN_PIN, DIVIDER_SELECT_PIN, DRIVER_MODE_PIN, CODING_FORMAT_PIN};
			pins2_q <= pins1_q;
			sclk_prev_q <= sync2_q[1];
		end
	end
	logic cs_n, sdi, sclk_rise;
	assign cs_n = sync2_q[2];
	assign sdi = sync2_q[0];
	assign sclk_rise = sync2_q[1] & ~sclk_prev_q;

	// register state
	logic [7:0] port_cfg_q, port_cfg_d, burst_q, burst_d, sel_q, sel_d, slip_q, slip_d;
	logic [2:0] divider_select_pin_q, divider_select_pin_d;
	logic [7:0] driver_mode_pin_q, driver_mode_pin_d, ddr_raw_q, ddr_raw_d, ddr_eff_q, ddr_eff_d;
	logic [7:0] ofs_c_q [NUM_CONV], ofs_c_d [NUM_CONV], ofs_f_q [NUM_CONV], ofs_f_d [NUM_CONV];
	logic [3:0] gain_c_q [NUM_CONV], gain_c_d [NUM_CONV];
	logic [7:0] gain_m_q [NUM_CONV], gain_m_d [NUM_CONV], gain_f_q [NUM_CONV], gain_f_d [NUM_CONV];
	logic [2:0] pwr_q [NUM_CONV], pwr_d [NUM_CONV];
	logic adv_d;

	// frame state
	frame_t state_q, state_d;
	logic [3:0] bitcnt_q, bitcnt_d;
	logic [15:0] sh_q, sh_d;
	logic rw_q, rw_d, ld_q, ld_d;
	logic [1:0] cnt_q, cnt_d, bytes_q, bytes_d;
	logic [12:0] addr_q, addr_d;
	logic [7:0] tx_q, tx_d, rdata;
	logic wr_stb;
	logic [7:0] wr_data;
	logic lsb_first, sel_ok, mapped, indexed;

	assign lsb_first = port_cfg_q[`B_LSB_FIRST];
	// exactly one converter named and no bit beyond the last converter
	assign sel_ok = ($countones(sel_q) == 1) && ((sel_q >> NUM_CONV) == 8'h00); // R6
	assign mapped = (addr_q[12:8] == 5'h00);
	assign indexed = mapped && addr_q[7:0] >= `A_OFS_C && addr_q[7:0] <= `A_PWR;

	always_comb begin
		state_d = state_q;
		bitcnt_d = bitcnt_q;
		sh_d = sh_q;
		rw_d = rw_q;
		cnt_d = cnt_q;
		bytes_d = bytes_q;
		addr_d = addr_q;
		ld_d = 1'b0;
		tx_d = ld_q ? rdata : tx_q;
		wr_stb = 1'b0;
		wr_data = 8'h00;
		if (cs_n) begin
			state_d = ST_IDLE;
			bitcnt_d = 4'h0;
		end else if (state_q == ST_IDLE) begin
			state_d = ST_INSTR;
			bitcnt_d = 4'h0;
		end else if (sclk_rise) begin
			unique case (state_q)
				ST_INSTR: begin
					sh_d = lsb_first ? {sdi, sh_q[15:1]} : {sh_q[14:0], sdi}; // R1
					bitcnt_d = bitcnt_q + 4'h1;
					if (bitcnt_q == `INSTR_LAST) begin
						rw_d = sh_d[15]; // R25
						cnt_d = sh_d[14:13]; // R25
						addr_d = sh_d[12:0]; // R25
						bytes_d = 2'h0;
						bitcnt_d = 4'h0;
						ld_d = sh_d[15];
						state_d = ST_DATA;
					end
				end
				ST_DATA: begin
					sh_d[7:0] = lsb_first ? {sdi, sh_q[7:1]} : {sh_q[6:0], sdi}; // R1
					bitcnt_d = bitcnt_q + 4'h1;
					if (bitcnt_q == `BYTE_LAST) begin
						bitcnt_d = 4'h0;
						wr_stb = ~rw_q;
						wr_data = sh_d[7:0];
						// address walks down in least-significant-first order
						addr_d = lsb_first ? addr_q - 13'h0001 : addr_q + 13'h0001;
						if (cnt_q == `CNT_CONT) begin
							if (addr_q[7:0] == burst_q) begin
								state_d = ST_DONE; // R4
							end
						end else if (bytes_q == cnt_q) begin
							state_d = ST_DONE;
						end
						if (bytes_q != 2'h3) begin
							bytes_d = bytes_q + 2'h1;
						end
						ld_d = rw_q && (state_d == ST_DATA);
					end
				end
				ST_DONE: begin
					state_d = ST_DONE;
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= ST_IDLE;
			bitcnt_q <= 4'h0;
			sh_q <= 16'h0000;
			rw_q <= 1'b0;
			cnt_q <= 2'h0;
			bytes_q <= 2'h0;
			addr_q <= 13'h0000;
			ld_q <= 1'b0;
			tx_q <= 8'h00;
		end else if (CE) begin
			state_q <= state_d;
			bitcnt_q <= bitcnt_d;
			sh_q <= sh_d;
			rw_q <= rw_d;
			cnt_q <= cnt_d;
			bytes_q <= bytes_d;
			addr_q <= addr_d;
			ld_q <= ld_d;
			tx_q <= tx_d;
		end
	end

	// read multiplexer
	always_comb begin
		rdata = 8'h00;
		if (indexed && !sel_ok) begin
			rdata = `ERR_CODE; // R7
		end else if (mapped) begin
			unique case (addr_q[7:0])
				`A_PORT_CFG: rdata = port_cfg_q;
				`A_BURST_END: rdata = burst_q;
				`A_DIE_ID: rdata = DIE_ID; // R5
				`A_DIE_REV: rdata = DIE_REV; // R5
				`A_CONV_SEL: rdata = sel_q;
				`A_SLIP: rdata = slip_q;
				`A_DIVIDER_SELECT_PIN: rdata = {5'h00, divider_select_pin_q};
				`A_DRIVER_MODE_PIN: rdata = driver_mode_pin_q;
				`A_DDR: rdata = ddr_raw_q;
				`A_CFG_STAT: rdata = ddr_eff_q;
				default: rdata = 8'h00;
			endcase
			for (int i = 0; i < NUM_CONV; i++) begin
				if (indexed && sel_q[i]) begin
					unique case (addr_q[7:0])
						`A_OFS_C: rdata = ofs_c_q[i];
						`A_OFS_F: rdata = ofs_f_q[i];
						`A_GAIN_C: rdata = {4'h0, gain_c_q[i]};
						`A_GAIN_M: rdata = gain_m_q[i];
						`A_GAIN_F: rdata = gain_f_q[i];
						default: rdata = {5'h00, pwr_q[i]};
					endcase
				end
			end
		end
	end

	// register writes
	always_comb begin
		port_cfg_d = port_cfg_q;
		burst_d = burst_q;
		sel_d = sel_q;
		slip_d = slip_q;
		divider_select_pin_d = divider_select_pin_q;
		driver_mode_pin_d = driver_mode_pin_q;
		ddr_raw_d = ddr_raw_q;
		ddr_eff_d = ddr_eff_q;
		ofs_c_d = ofs_c_q;
		ofs_f_d = ofs_f_q;
		gain_c_d = gain_c_q;
		gain_m_d = gain_m_q;
		gain_f_d = gain_f_q;
		pwr_d = pwr_q;
		adv_d = 1'b0;
		for (int i = 0; i < NUM_CONV; i++) begin
			if (CAL_LOAD) begin
				ofs_c_d[i] = CAL_TRIM[i][`CAL_OFS_C_LSB +: 8]; // R9
				ofs_f_d[i] = CAL_TRIM[i][`CAL_OFS_F_LSB +: 8]; // R9
				gain_c_d[i] = CAL_TRIM[i][`CAL_GAIN_C_LSB +: 4]; // R9
				gain_m_d[i] = CAL_TRIM[i][`CAL_GAIN_M_LSB +: 8]; // R9
				gain_f_d[i] = CAL_TRIM[i][`CAL_GAIN_F_LSB +: 8]; // R9
			end
		end
		if (wr_stb && mapped) begin
			if (addr_q[7:0] == `A_PORT_CFG && wr_data[`B_SOFT_RST]) begin // R2 R15
				// soft reset: power, divider and output mode stay as they are
				port_cfg_d = `RST_BYTE; // R2
				burst_d = `RST_BYTE; // R2
				sel_d = `RST_BYTE; // R6
				slip_d = `RST_BYTE;
				ddr_raw_d = `RST_BYTE;
				ddr_eff_d = `RST_BYTE; // R22
				for (int i = 0; i < NUM_CONV; i++) begin
					ofs_c_d[i] = CAL_TRIM[i][`CAL_OFS_C_LSB +: 8]; // R9
					ofs_f_d[i] = CAL_TRIM[i][`CAL_OFS_F_LSB +: 8];
					gain_c_d[i] = CAL_TRIM[i][`CAL_GAIN_C_LSB +: 4];
					gain_m_d[i] = CAL_TRIM[i][`CAL_GAIN_M_LSB +: 8];
					gain_f_d[i] = CAL_TRIM[i][`CAL_GAIN_F_LSB +: 8];
				end
			end else begin
				unique case (addr_q[7:0])
					`A_PORT_CFG: port_cfg_d = wr_data & 8'hDF; // R24
					`A_BURST_END: burst_d = wr_data; // R4
					`A_CONV_SEL: sel_d = wr_data; // R6
					`A_SLIP: begin
						slip_d = wr_data;
						adv_d = wr_data[`B_SLIP] & ~slip_q[`B_SLIP] & (DIV_RATIO == DIV_4); // R18
					end
					`A_DIVIDER_SELECT_PIN: divider_select_pin_d = wr_data[2:0]; // R19
					`A_DRIVER_MODE_PIN: driver_mode_pin_d = wr_data; // R20 R21
					`A_DDR: begin
						// the effective value flips by whatever the host XOR leaves over
						ddr_eff_d = wr_data ^ ddr_raw_q ^ ddr_eff_q; // R23
						ddr_raw_d = wr_data;
					end
					default: begin
					end
				endcase
				for (int i = 0; i < NUM_CONV; i++) begin
					if (sel_ok && sel_q[i]) begin
						unique case (addr_q[7:0])
							`A_OFS_C: ofs_c_d[i] = wr_data; // R8
							`A_OFS_F: ofs_f_d[i] = wr_data; // R8
							`A_GAIN_C: gain_c_d[i] = wr_data[3:0]; // R11
							`A_GAIN_M: gain_m_d[i] = wr_data; // R12
							`A_GAIN_F: gain_f_d[i] = wr_data; // R12
							`A_PWR: pwr_d[i] = wr_data[2:0]; // R14
							default: begin
							end
						endcase
					end
				end
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			port_cfg_q <= `RST_BYTE;
			burst_q <= `RST_BYTE;
			sel_q <= `RST_BYTE;
			slip_q <= `RST_BYTE;
			divider_select_pin_q <= `RST_FIELD;
			driver_mode_pin_q <= `RST_BYTE;
			ddr_raw_q <= `RST_BYTE;
			ddr_eff_q <= `RST_BYTE;
			DIV_ADVANCE <= 1'b0;
			for (int i = 0; i < NUM_CONV; i++) begin
				// mid-scale, coarse gain zero, until the calibration engine loads its result
				ofs_c_q[i] <= `RST_TRIM;
				ofs_f_q[i] <= `RST_TRIM;
				gain_c_q[i] <= `RST_GAIN_C;
				gain_m_q[i] <= `RST_TRIM;
				gain_f_q[i] <= `RST_TRIM;
				pwr_q[i] <= `RST_FIELD;
			end
		end else if (CE) begin
			port_cfg_q <= port_cfg_d;
			burst_q <= burst_d;
			sel_q <= sel_d;
			slip_q <= slip_d;
			divider_select_pin_q <= divider_select_pin_d;
			driver_mode_pin_q <= driver_mode_pin_d;
			ddr_raw_q <= ddr_raw_d;
			ddr_eff_q <= ddr_eff_d;
			DIV_ADVANCE <= adv_d;
			ofs_c_q <= ofs_c_d;
			ofs_f_q <= ofs_f_d;
			gain_c_q <= gain_c_d;
			gain_m_q <= gain_m_d;
			gain_f_q <= gain_f_d;
			pwr_q <= pwr_d;
		end
	end

	// resolved modes and serial outputs, all registered
	logic sdo_bit;
	assign sdo_bit = tx_q[lsb_first ? bitcnt_q[2:0] : 3'h7 - bitcnt_q[2:0]];
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			DIV_RATIO <= DIV_1;
			DRIVER_MODE <= DRV_2MA;
			CODING <= COD_TWOS;
			SERIAL_DATA_O <= 1'b0;
			SERIAL_DATA_OE <= 1'b0;
			SERIAL_OUT_PIN_O <= 1'b0;
			for (int i = 0; i < NUM_CONV; i++) begin
				PWR_MODE[i] <= PM_NORMAL;
			end
		end else if (CE) begin
			DIV_RATIO <= div_t'(pick(divider_select_pin_q, pins2_q[5:4])); // R19
			DRIVER_MODE <= drive_t'(pick(driver_mode_pin_q[`F_DRIVER_LSB +: 3], pins2_q[3:2])); // R20
			CODING <= coding_t'(pick(driver_mode_pin_q[`F_CODING_LSB +: 3], pins2_q[1:0])); // R21
			SERIAL_DATA_O <= sdo_bit;
			// three-wire reads turn the data pin round only inside the data phase
			SERIAL_DATA_OE <= (state_q == ST_DATA) && rw_q && !cs_n && !port_cfg_q[`B_SDO_ACT];
			SERIAL_OUT_PIN_O <= (state_q == ST_DATA) && rw_q && sdo_bit;
			for (int i = 0; i < NUM_CONV; i++) begin
				PWR_MODE[i] <= pwr_mode_t'(pick(pwr_q[i], pins2_q[7:6])); // R13
			end
		end
	end
	// the dedicated output is driven whenever enabled, selected or not
	assign SERIAL_OUT_PIN_OE = port_cfg_q[`B_SDO_ACT]; // R24
	assign DDR_ENABLE = ddr_eff_q[`B_DDR_EN];
	assign DLL_SLOW = ddr_eff_q[`B_DLL_SLOW]; // R22
	for (genvar g = 0; g < NUM_CONV; g++) begin : g_trim
		assign TRIM_OFS_C[g] = ofs_c_q[g];
		assign TRIM_OFS_F[g] = ofs_f_q[g];
		assign TRIM_GAIN_C[g] = gain_c_q[g];
		assign TRIM_GAIN_M[g] = gain_m_q[g];
		assign TRIM_GAIN_F[g] = gain_f_q[g];
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic soft_wr;
	assign soft_wr = CE && wr_stb && mapped && addr_q[7:0] == `A_PORT_CFG && wr_data[`B_SOFT_RST];
	err_code_a: assert property (CE && ld_q && indexed && !sel_ok |=> tx_q == `ERR_CODE) // R7
		else $error("bad index read did not return error code");
	soft_keep_a: assert property (soft_wr |=> pwr_q[0] == $past(pwr_q[0])
		&& divider_select_pin_q == $past(divider_select_pin_q) && driver_mode_pin_q == $past(driver_mode_pin_q)) // R15
		else $error("soft reset disturbed an exempt register");
	soft_clear_a: assert property (soft_wr |=> sel_q == 8'h00 && burst_q == 8'h00
		&& port_cfg_q == 8'h00 && ddr_eff_q == 8'h00) // R2
		else $error("soft reset left a register at a non-default value");
	bit_order_a: assert property (CE && sclk_rise && !cs_n && state_q == ST_INSTR && lsb_first
		|=> sh_q[15] == $past(sdi)) // R1
		else $error("least-significant-first bit not shifted in at the top");
	burst_stop_a: assert property (CE && sclk_rise && !cs_n && state_q == ST_DATA
		&& bitcnt_q == 4'h7 && cnt_q == 2'h3 && addr_q[7:0] == burst_q |=> state_q == ST_DONE) // R4
		else $error("continuous transfer ran past the burst end address");
	slip_pulse_a: assert property (CE && wr_stb && mapped && addr_q[7:0] == `A_SLIP
		&& wr_data[0] && !slip_q[0] && DIV_RATIO == DIV_4 |=> DIV_ADVANCE ##1 !DIV_ADVANCE) // R18
		else $error("phase advance pulse missing or too long");
	pwr_index_a: assert property (CE && NUM_CONV > 1 && wr_stb && addr_q == {5'h00, `A_PWR}
		&& sel_q == 8'h01 |=> $stable(pwr_q[NUM_CONV-1])) // R14
		else $error("power write reached an unselected converter");
	pwr_pin_a: assert property (CE && pwr_q[0] == 3'h0 && pins2_q[7:6] != 2'h3
		|=> PWR_MODE[0] == $past(pins2_q[7:6])) // R13
		else $error("power mode did not follow the pin");
	ddr_xor_a: assert property (CE && wr_stb && addr_q == {5'h00, `A_DDR}
		|=> ##1 DLL_SLOW == ($past(wr_data[`B_DLL_SLOW], 2)
		^ $past(ddr_raw_q[`B_DLL_SLOW], 2) ^ $past(ddr_eff_q[`B_DLL_SLOW], 2))) // R23
		else $error("range bit did not follow the XOR write");
	sdo_pin_a: assert property (!(SERIAL_DATA_OE && SERIAL_OUT_PIN_OE)) // R24
		else $error("both serial outputs driven together");
	read_c: cover property (CE && ld_q && sel_ok && indexed);
	soft_c: cover property (soft_wr);
	burst_c: cover property (state_q == ST_DATA && cnt_q == 2'h3 ##1 state_q == ST_DONE);
endmodule
`default_nettype wire

// >>> include/adc_cfg_map.svh
// register offsets, field positions, reset values and frame counts of the converter config port
`ifndef ADC_CFG_MAP_SVH
`define ADC_CFG_MAP_SVH
`define A_PORT_CFG 8'h00
`define A_BURST_END 8'h02
`define A_DIE_ID 8'h08
`define A_DIE_REV 8'h09
`define A_CONV_SEL 8'h10
`define A_OFS_C 8'h20
`define A_OFS_F 8'h21
`define A_GAIN_C 8'h22
`define A_GAIN_M 8'h23
`define A_GAIN_F 8'h24
`define A_PWR 8'h25
`define A_SLIP 8'h71
`define A_DIVIDER_SELECT_PIN 8'h72
`define A_DRIVER_MODE_PIN 8'h73
`define A_DDR 8'h74
`define A_CFG_STAT 8'h75
`define B_SDO_ACT 7
`define B_LSB_FIRST 6
`define B_SOFT_RST 5
`define B_SLIP 0
`define B_DLL_SLOW 6
`define B_DDR_EN 0
`define F_DRIVER_LSB 5
`define F_CODING_LSB 0
`define CAL_OFS_C_LSB 32
`define CAL_OFS_F_LSB 24
`define CAL_GAIN_C_LSB 16
`define CAL_GAIN_M_LSB 8
`define CAL_GAIN_F_LSB 0
`define RST_BYTE 8'h00
`define RST_TRIM 8'h80
`define RST_GAIN_C 4'h0
`define RST_FIELD 3'h0
`define ERR_CODE 8'hAD
`define INSTR_LAST 4'hF
`define BYTE_LAST 4'h7
`define CNT_CONT 2'h3
`endif

// >>> include/adc_cfg_pkg.sv
// types shared by the converter configuration port
package adc_cfg_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_INSTR = 2'b01,
		ST_DATA = 2'b10,
		ST_DONE = 2'b11
	} frame_t;
	typedef enum logic [1:0] {PM_NORMAL = 2'b00, PM_NAP = 2'b01, PM_SLEEP = 2'b10} pwr_mode_t;
	typedef enum logic [1:0] {DIV_1 = 2'b00, DIV_2 = 2'b01, DIV_4 = 2'b10} div_t;
	typedef enum logic [1:0] {DRV_2MA = 2'b00, DRV_3MA = 2'b01, DRV_CMOS = 2'b10} drive_t;
	typedef enum logic [1:0] {COD_TWOS = 2'b00, COD_GRAY = 2'b01, COD_OFFSET = 2'b10} coding_t;
endpackage

// >>> sim/host_model.sv
// serial-port master model driving select, clock and data of the config port
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk,
	input wire logic dev_o,
	input wire logic dev_oe,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	output logic csb_n,
	output logic sclk,
	output wire logic sdio
);
	logic m_val = 1'b0;
	logic m_drv = 1'b0;
	logic lsb = 1'b0;
	logic four_wire = 1'b0;
	wire logic sdo_w;
	// a released line shows the inverse of the last bit, so a stale value never passes
	assign sdio = dev_oe ? dev_o : (m_drv ? m_val : ~m_val);
	// dedicated output carries a pull-up
	assign sdo_w = sdo_oe ? sdo_o : 1'b1;
	initial begin
		csb_n = 1'b1;
		sclk = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// eight clocks per half period keeps reads inside the slow-clock limit
	task automatic send_bit(input logic b);
		m_val = b;
		m_drv = 1'b1;
		tick(8);
		sclk = 1'b1;
		tick(8);
		sclk = 1'b0;
	endtask
	task automatic get_bit(output logic b);
		m_drv = 1'b0;
		tick(8);
		b = four_wire ? sdo_w : sdio;
		sclk = 1'b1;
		tick(8);
		sclk = 1'b0;
	endtask
	task automatic frame(input logic is_rd, input logic [1:0] cnt, input logic [12:0] a,
		input int nb, input logic [7:0] wd [4], output logic [7:0] rdat [4]);
		logic [15:0] ins;
		logic b;
		ins = {is_rd, cnt, a};
		csb_n = 1'b0;
		tick(4);
		for (int i = 0; i < 16; i++) begin
			send_bit(lsb ? ins[i] : ins[15 - i]);
		end
		for (int k = 0; k < nb; k++) begin
			for (int i = 0; i < 8; i++) begin
				if (is_rd) begin
					get_bit(b);
					rdat[k][lsb ? i : 7 - i] = b;
				end else begin
					send_bit(wd[k][lsb ? i : 7 - i]);
				end
			end
		end
		m_drv = 1'b0;
		tick(4);
		csb_n = 1'b1;
		tick(4);
	endtask
	task automatic reg_write(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] w [4];
		logic [7:0] q [4];
		w = '{d, 8'h00, 8'h00, 8'h00};
		frame(1'b0, 2'h0, a, 1, w, q);
	endtask
	task automatic reg_read(input logic [12:0] a, output logic [7:0] d);
		logic [7:0] w [4];
		logic [7:0] q [4];
		w = '{8'h00, 8'h00, 8'h00, 8'h00};
		frame(1'b1, 2'h0, a, 1, w, q);
		d = q[0];
	endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the converter configuration port
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_map.svh"
module testbench;
	import adc_cfg_pkg::*;
	localparam logic [7:0] ID_V = 8'h3C; // arbitrary value
	localparam logic [7:0] REV_V = 8'h07; // arbitrary value
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic cal_load = 1'b0;
	logic [39:0] cal_trim [2] = '{40'h71_6205_93A4, 40'h8E_9D0A_6C5B};
	pwr_mode_t pd_pin = PM_SLEEP;
	div_t dv_pin = DIV_1;
	drive_t drv_pin = DRV_CMOS;
	coding_t cod_pin = COD_TWOS;
	wire logic csb_n, sclk, sdio, d_o, d_oe, s_o, s_oe;
	pwr_mode_t pwr [2];
	div_t div_r;
	drive_t drv_r;
	coding_t cod_r;
	logic adv, ddr, dll;
	logic [7:0] t_oc [2], t_of [2], t_gm [2], t_gf [2];
	logic [3:0] t_gc [2];
	logic [7:0] r, r2;
	int n_fail = 0;
	int checks_done = 0;
	int n_adv = 0;
	int cycles = 0;
	always #20 clk = ~clk;
	adc_cfg_regs #(.NUM_CONV(2), .DIE_ID(ID_V), .DIE_REV(REV_V)) i_adc_cfg_regs (
		.CLK(clk), .RST_N(rst_n), .CE(ce), .CHIP_SELECT_BAR(csb_n), .SCLK(sclk),
		.SERIAL_DATA_I(sdio), .SERIAL_DATA_O(d_o), .SERIAL_DATA_OE(d_oe),
		.SERIAL_OUT_PIN_O(s_o), .SERIAL_OUT_PIN_OE(s_oe), .CAL_LOAD(cal_load),
		.CAL_TRIM(cal_trim), .POWER_DOWN_PIN(pd_pin), .DIVIDER_SELECT_PIN(dv_pin),
		.DRIVER_MODE_PIN(drv_pin), .CODING_FORMAT_PIN(cod_pin), .PWR_MODE(pwr),
		.DIV_RATIO(div_r), .DRIVER_MODE(drv_r), .CODING(cod_r), .DIV_ADVANCE(adv),
		.DDR_ENABLE(ddr), .DLL_SLOW(dll), .TRIM_OFS_C(t_oc), .TRIM_OFS_F(t_of),
		.TRIM_GAIN_C(t_gc), .TRIM_GAIN_M(t_gm), .TRIM_GAIN_F(t_gf)
	);
	host_model host (
		.clk(clk), .dev_o(d_o), .dev_oe(d_oe), .sdo_o(s_o), .sdo_oe(s_oe),
		.csb_n(csb_n), .sclk(sclk), .sdio(sdio)
	);
	// ceiling sits well above the roughly 29k cycles the sequence needs
	always @(posedge clk) begin
		cycles++;
		if (adv === 1'b1) n_adv++;
		if (cycles == 60000) begin
			n_fail++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_mode(input string nm, input logic [1:0] e, input logic [1:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.reg_write({5'h00, a}, d);
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		host.reg_read({5'h00, a}, r);
		chk_byte(nm, e, r);
	endtask
	task automatic t_reset();
		chk_mode("pwr0 pin", PM_SLEEP, pwr[0]);
		chk_mode("dll", 2'h0, {1'b0, dll});
		rdchk("index", `A_CONV_SEL, 8'h00);
		rdchk("id", `A_DIE_ID, ID_V);
		rdchk("rev", `A_DIE_REV, REV_V);
		rdchk("no index", `A_OFS_C, 8'hAD);
		cal_load = 1'b1;
		wt(1);
		cal_load = 1'b0;
		wr(`A_CONV_SEL, 8'h01);
		rdchk("cal oc", `A_OFS_C, 8'h71);
		chk_byte("cal gf1", 8'h5B, t_gf[1]);
		wr(`A_CONV_SEL, 8'h03);
		rdchk("two index", `A_GAIN_M, 8'hAD);
		$display("t_reset done");
	endtask
	task automatic t_trims();
		wr(`A_CONV_SEL, 8'h01);
		host.reg_read({5'h00, `A_OFS_F}, r);
		wr(`A_OFS_F, r + 8'h01);
		chk_byte("of0", 8'h63, t_of[0]);
		chk_byte("of1", 8'h9D, t_of[1]);
		wr(`A_GAIN_C, 8'h0C);
		chk_byte("gc0", 8'h0C, {4'h0, t_gc[0]});
		wr(`A_GAIN_M, 8'hFF);
		rdchk("gm0", `A_GAIN_M, 8'hFF);
		// with the clock enable low a whole frame must leave no trace
		ce = 1'b0;
		wr(`A_GAIN_M, 8'h00);
		ce = 1'b1;
		wt(4);
		rdchk("ce frozen", `A_GAIN_M, 8'hFF);
		wr(`A_OFS_C, 8'h00);
		chk_byte("oc0", 8'h00, t_oc[0]);
		wr(`A_DIE_ID, 8'h00);
		rdchk("id ro", `A_DIE_ID, ID_V);
		$display("t_trims done");
	endtask
	task automatic t_power();
		wr(`A_CONV_SEL, 8'h01);
		wr(`A_PWR, 8'h02);
		chk_mode("nap0", PM_NAP, pwr[0]);
		chk_mode("pin1", PM_SLEEP, pwr[1]);
		wr(`A_CONV_SEL, 8'h02);
		wr(`A_PWR, 8'h02);
		chk_mode("nap1", PM_NAP, pwr[1]);
		wr(`A_CONV_SEL, 8'h01);
		wr(`A_PWR, 8'h01);
		wr(`A_CONV_SEL, 8'h02);
		wr(`A_PWR, 8'h01);
		chk_mode("norm0", PM_NORMAL, pwr[0]);
		chk_mode("norm1", PM_NORMAL, pwr[1]);
		pd_pin = PM_NAP;
		wr(`A_PWR, 8'h04);
		chk_mode("sleep1", PM_SLEEP, pwr[1]);
		wr(`A_PWR, 8'h00);
		chk_mode("defer1", PM_NAP, pwr[1]);
		chk_mode("keep0", PM_NORMAL, pwr[0]);
		$display("t_power done");
	endtask
	task automatic t_modes();
		logic [2:0] cd [4] = '{3'b001, 3'b100, 3'b010, 3'b000};
		div_t ed [4] = '{DIV_1, DIV_4, DIV_2, DIV_1};
		drive_t ev [4] = '{DRV_2MA, DRV_CMOS, DRV_3MA, DRV_CMOS};
		coding_t ec [4] = '{COD_TWOS, COD_OFFSET, COD_GRAY, COD_TWOS};
		for (int i = 0; i < 4; i++) begin
			wr(`A_DIVIDER_SELECT_PIN, {5'h00, cd[i]});
			wr(`A_DRIVER_MODE_PIN, {cd[i], 2'b00, cd[i]});
			chk_mode("div", ed[i], div_r);
			chk_mode("drv", ev[i], drv_r);
			chk_mode("cod", ec[i], cod_r);
		end
		$display("t_modes done");
	endtask
	task automatic t_slip();
		wr(`A_DIVIDER_SELECT_PIN, 8'h04);
		n_adv = 0;
		wr(`A_SLIP, 8'h00);
		wr(`A_SLIP, 8'h01);
		chk_byte("slip by four", 8'h01, n_adv[7:0]);
		wr(`A_DIVIDER_SELECT_PIN, 8'h02);
		wr(`A_SLIP, 8'h00);
		wr(`A_SLIP, 8'h01);
		chk_byte("slip by two", 8'h01, n_adv[7:0]);
		$display("t_slip done");
	endtask
	task automatic t_ddr();
		logic [7:0] want [2] = '{8'h41, 8'h01};
		for (int i = 0; i < 2; i++) begin
			host.reg_read({5'h00, `A_DDR}, r);
			host.reg_read({5'h00, `A_CFG_STAT}, r2);
			wr(`A_DDR, r ^ r2 ^ want[i]);
			chk_mode("ddr", {1'b0, want[i][0]}, {1'b0, ddr});
			chk_mode("dll", {1'b0, want[i][6]}, {1'b0, dll});
			rdchk("status", `A_CFG_STAT, want[i]);
		end
		$display("t_ddr done");
	endtask
	task automatic t_soft();
		wr(`A_DIVIDER_SELECT_PIN, 8'h04);
		wr(`A_DRIVER_MODE_PIN, 8'h44);
		wr(`A_BURST_END, 8'h05);
		wr(`A_CONV_SEL, 8'h01);
		wr(`A_OFS_C, 8'h12);
		wr(`A_PORT_CFG, 8'h3C);
		rdchk("burst", `A_BURST_END, 8'h00);
		rdchk("index", `A_CONV_SEL, 8'h00);
		chk_byte("oc0 reload", 8'h71, t_oc[0]);
		rdchk("div kept", `A_DIVIDER_SELECT_PIN, 8'h04);
		rdchk("out kept", `A_DRIVER_MODE_PIN, 8'h44);
		chk_mode("div mode", DIV_4, div_r);
		chk_mode("pwr0 kept", PM_NORMAL, pwr[0]);
		$display("t_soft done");
	endtask
	task automatic t_lsb();
		wr(`A_PORT_CFG, 8'h5A);
		host.lsb = 1'b1;
		rdchk("lsb id", `A_DIE_ID, ID_V);
		wr(`A_BURST_END, 8'h35);
		rdchk("lsb burst", `A_BURST_END, 8'h35);
		wr(`A_PORT_CFG, 8'h18);
		host.lsb = 1'b0;
		rdchk("msb burst", `A_BURST_END, 8'h35);
		$display("t_lsb done");
	endtask
	task automatic t_burst();
		logic [7:0] w [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
		logic [7:0] q [4];
		wr(`A_CONV_SEL, 8'h01);
		wr(`A_BURST_END, 8'h22);
		host.frame(1'b0, 2'h3, {5'h00, `A_OFS_C}, 4, w, q);
		chk_byte("b oc", 8'h11, t_oc[0]);
		chk_byte("b of", 8'h22, t_of[0]);
		chk_byte("b gc", 8'h03, {4'h0, t_gc[0]});
		chk_byte("b gm", 8'h93, t_gm[0]);
		wr(`A_PORT_CFG, 8'h99);
		chk_mode("sdo on", 2'h1, {1'b0, s_oe});
		host.four_wire = 1'b1;
		rdchk("sdo rev", `A_DIE_REV, REV_V);
		wr(`A_PORT_CFG, 8'h18);
		host.four_wire = 1'b0;
		chk_mode("sdo off", 2'h0, {1'b0, s_oe});
		$display("t_burst done");
	endtask
	initial begin
		wt(12);
		rst_n = 1'b1;
		wt(4);
		t_reset();
		t_trims();
		t_power();
		t_modes();
		t_slip();
		t_ddr();
		t_soft();
		t_lsb();
		t_burst();
		final_report();
	end
endmodule
`default_nettype wire
